/* File: pkg/port_ctl_regs.svh */
// Constants and the summary of operation for the port pin function block.
// Summary of operation
// - Port A: four two-way pins, direction chosen per bit.
// - Port A input pin gets internal pull-up when its pull-up bit is set.
// - Port B pins act as digital I/O or analog converter inputs, per bit.
// - In control mode port B pins feed the four analog input channels.
// - Port C pins 0 and 1 switch between port mode and alternate function per bit.
// - Two lowest port C pins carry timer signals and interrupt inputs.
// - Fifth port C pin is input-only and acts as reset after power-on.
// - Port E: only first and fourth pins have software pull-ups.
// - Port E oscillator pins are pulled low while device is in reset.
// - Each external interrupt detects rising, falling or both edges.
// - First timer input is count clock and capture trigger for two registers.
// - Port D: eight pins, each with direction and pull-up bit.
`ifndef PORT_CTL_REGS_SVH
`define PORT_CTL_REGS_SVH
`define DIR_RESET4     4'hF
`define DIR_RESET8     8'hFF
`define PU_RESET4      4'h0
`define PU_RESET8      8'h00
`define OSC_PD_RESET4  4'h6
`define E_PU_MASK      4'h9
`define EDGE_RISE_BIT  0
`define EDGE_FALL_BIT  1
`define IRQ_COUNT      4
`endif

/* File: pkg/port_ctl_pkg.sv */
// Types shared by the port pin function block.
package port_ctl_pkg;
   typedef logic [1:0] edge_sel_t;
   typedef enum logic {RESET_FUNC, INPUT_FUNC} shared_pin_mode_t;
endpackage : port_ctl_pkg

/* File: src/port_pin_function_control.sv */
// Pin-level port logic with direction, pull-up and alternate-function muxing.
`timescale 1ns/1ps
`default_nettype none
`include "port_ctl_regs.svh"
module port_pin_function_control (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic [3:0] PORT_A_DIRECTION,
   input  wire logic [3:0] PORT_A_PULLUP,
   input  wire logic [3:0] PORT_A_OUT_DATA,
   input  wire logic [3:0] PORT_A_PINS_IN,
   output var  logic [3:0] PORT_A_PINS_OUT,
   output var  logic [3:0] PORT_A_PINS_OE,
   output var  logic [3:0] PORT_A_PU_EN,
   output var  logic [3:0] PORT_A_READ,
   input  wire logic [3:0] PORT_B_DIRECTION,
   input  wire logic [3:0] PORT_B_PULLUP,
   input  wire logic [3:0] PORT_B_ANALOG_SEL,
   input  wire logic [3:0] PORT_B_OUT_DATA,
   input  wire logic [3:0] PORT_B_PINS_IN,
   output var  logic [3:0] PORT_B_PINS_OUT,
   output var  logic [3:0] PORT_B_PINS_OE,
   output var  logic [3:0] PORT_B_PU_EN,
   output var  logic [3:0] PORT_B_READ,
   output var  logic [3:0] ANALOG_INPUTS_EN,
   input  wire logic [3:0] PORT_C_DIRECTION,
   input  wire logic [3:0] PORT_C_PULLUP,
   input  wire logic [3:0] PORT_C_ALT_SEL,
   input  wire logic [3:0] PORT_C_OUT_DATA,
   input  wire logic [3:0] PORT_C_PINS_IN,
   output var  logic [3:0] PORT_C_PINS_OUT,
   output var  logic [3:0] PORT_C_PINS_OE,
   output var  logic [3:0] PORT_C_PU_EN,
   output var  logic [3:0] PORT_C_READ,
   input  wire logic       RESET_SHARED_INPUT_PIN,
   input  wire logic       SHARED_PIN_AS_INPUT,
   input  wire logic       POWER_ON,
   output var  logic       SHARED_PIN_RESET_N,
   output var  logic       SHARED_PIN_READ,
   input  wire logic [7:0] PORT_D_DIRECTION,
   input  wire logic [7:0] PORT_D_PULLUP,
   input  wire logic [7:0] PORT_D_ALT_SEL,
   input  wire logic [7:0] PORT_D_OUT_DATA,
   input  wire logic [7:0] PORT_D_PINS_IN,
   output var  logic [7:0] PORT_D_PINS_OUT,
   output var  logic [7:0] PORT_D_PINS_OE,
   output var  logic [7:0] PORT_D_PU_EN,
   output var  logic [7:0] PORT_D_READ,
   input  wire logic [3:0] PORT_E_DIRECTION,
   input  wire logic [3:0] PORT_E_PULLUP,
   input  wire logic [3:0] PORT_E_OUT_DATA,
   input  wire logic [3:0] PORT_E_PINS_IN,
   output var  logic [3:0] PORT_E_PINS_OUT,
   output var  logic [3:0] PORT_E_PINS_OE,
   output var  logic [3:0] PORT_E_PU_EN,
   output var  logic [3:0] PORT_E_PD_EN,
   output var  logic [3:0] PORT_E_READ,
   input  wire logic       OUTPUT_ONLY_DATA,
   output var  logic       OUTPUT_ONLY_PIN,
   input  wire logic [7:0] IRQ_EDGE_SEL,
   output var  logic [3:0] EXT_IRQ_PULSE,
   input  wire logic       TIMER_WIDE_OUT,
   input  wire logic       TIMER_NARROW_OUT,
   input  wire logic       SERIAL_TX_OUT,
   output var  logic       SERIAL_RX_IN,
   output var  logic       TIMER_COUNT_CLK,
   output var  logic       CAPTURE_REG_A_TRIG,
   output var  logic       CAPTURE_REG_B_TRIG,
   output var  logic       TIMER_CAPTURE_IN
);
   // Direction bit high means input, so reset value all ones gives inputs.
   logic [3:0] a_out, a_oe, a_pu, a_rd, b_out, b_oe, b_pu, b_rd, b_an;
   logic [3:0] c_out, c_oe, c_pu, c_rd, e_out, e_oe, e_pu, e_pd, e_rd;
   logic [7:0] d_out, d_oe, d_pu, d_rd;
   logic [3:0] irq_src, irq_prev_reg, irq_prev_next, irq_det;
   logic       shared_rst_n, shared_rd, rx, tclk, cap_a, cap_b, tcap;
   logic       ti_prev_reg, ti_prev_next;
   // The edge history holds the reset zero, not a pin sample, for one cycle after reset.
   // Detection waits until it holds a real pin sample, so a pin that
   // idles high cannot fake an edge.
   logic       armed_reg, armed_next;
   port_ctl_pkg::shared_pin_mode_t mode_reg, mode_next;

   function automatic logic edge_hit(input port_ctl_pkg::edge_sel_t sel,
                                     input logic prev, input logic cur);
      edge_hit = (sel[`EDGE_RISE_BIT] & ~prev & cur)
               | (sel[`EDGE_FALL_BIT] & prev & ~cur);
   endfunction : edge_hit

   always_comb begin
      a_oe  = ~PORT_A_DIRECTION;
      a_out = PORT_A_OUT_DATA & a_oe;
      a_pu  = PORT_A_PULLUP & PORT_A_DIRECTION;
      a_rd  = PORT_A_PINS_IN;
      b_an  = PORT_B_ANALOG_SEL;
      b_oe  = ~PORT_B_DIRECTION & ~b_an;
      b_out = PORT_B_OUT_DATA & b_oe;
      b_pu  = PORT_B_PULLUP & PORT_B_DIRECTION & ~b_an;
      b_rd  = PORT_B_PINS_IN & ~b_an;
      c_oe  = ~PORT_C_DIRECTION;
      c_out = PORT_C_OUT_DATA;
      if (PORT_C_ALT_SEL[1]) begin
         c_oe[1]  = 1'b1;
         c_out[1] = TIMER_WIDE_OUT;
      end
      if (PORT_C_ALT_SEL[0]) begin
         c_oe[0] = 1'b0;
      end
      c_out = c_out & c_oe;
      c_pu  = PORT_C_PULLUP & ~c_oe;
      c_rd  = PORT_C_PINS_IN;
      d_oe  = ~PORT_D_DIRECTION;
      d_out = PORT_D_OUT_DATA;
      if (PORT_D_ALT_SEL[2]) begin
         d_oe[2]  = 1'b1;
         d_out[2] = TIMER_NARROW_OUT;
      end
      if (PORT_D_ALT_SEL[3]) begin
         d_oe[3]  = 1'b1;
         d_out[3] = SERIAL_TX_OUT;
      end
      if (PORT_D_ALT_SEL[4]) begin
         d_oe[4] = 1'b0;
      end
      d_out = d_out & d_oe;
      d_pu  = PORT_D_PULLUP & ~d_oe;
      d_rd  = PORT_D_PINS_IN;
      e_oe  = ~PORT_E_DIRECTION;
      e_out = PORT_E_OUT_DATA & e_oe;
      e_pu  = PORT_E_PULLUP & PORT_E_DIRECTION & `E_PU_MASK;
      e_pd  = 4'h0;
      e_rd  = PORT_E_PINS_IN;
      rx    = PORT_D_PINS_IN[4];
      // Edge detectors watch the pin levels whichever mode owns them.
      irq_src = {PORT_D_PINS_IN[1], PORT_C_PINS_IN[1],
                 PORT_D_PINS_IN[3], PORT_C_PINS_IN[0]};
      irq_prev_next = irq_src;
      armed_next    = 1'b1;
      for (int i = 0; i < `IRQ_COUNT; i++) begin
         irq_det[i] = armed_reg & edge_hit(IRQ_EDGE_SEL[2*i +: 2],
                               irq_prev_reg[i], irq_src[i]);
      end
      ti_prev_next = PORT_C_PINS_IN[0];
      tclk  = PORT_C_ALT_SEL[0] & PORT_C_PINS_IN[0];
      cap_a = armed_reg & PORT_C_ALT_SEL[0] & ~ti_prev_reg
            & PORT_C_PINS_IN[0];
      cap_b = cap_a;
      tcap  = PORT_C_ALT_SEL[1] & PORT_C_PINS_IN[1];
      // Power-on always restores the reset role, whatever was configured.
      if (POWER_ON) begin
         mode_next = port_ctl_pkg::RESET_FUNC;
      end else if (SHARED_PIN_AS_INPUT) begin
         mode_next = port_ctl_pkg::INPUT_FUNC;
      end else begin
         mode_next = port_ctl_pkg::RESET_FUNC;
      end
      // An input-use pin relies on the board pull-up to stay idle high.
      shared_rd    = (mode_reg == port_ctl_pkg::INPUT_FUNC) &
                     RESET_SHARED_INPUT_PIN;
      shared_rst_n = (mode_reg == port_ctl_pkg::INPUT_FUNC) |
                     RESET_SHARED_INPUT_PIN;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PORT_A_PINS_OUT <= 4'h0;
         PORT_A_PINS_OE  <= 4'h0;
         PORT_A_PU_EN    <= `PU_RESET4;
         PORT_A_READ     <= 4'h0;
         PORT_B_PINS_OUT <= 4'h0;
         PORT_B_PINS_OE  <= 4'h0;
         PORT_B_PU_EN    <= `PU_RESET4;
         PORT_B_READ     <= 4'h0;
         ANALOG_INPUTS_EN <= 4'h0;
         PORT_C_PINS_OUT <= 4'h0;
         PORT_C_PINS_OE  <= 4'h0;
         PORT_C_PU_EN    <= `PU_RESET4;
         PORT_C_READ     <= 4'h0;
         PORT_D_PINS_OUT <= 8'h00;
         PORT_D_PINS_OE  <= 8'h00;
         PORT_D_PU_EN    <= `PU_RESET8;
         PORT_D_READ     <= 8'h00;
         PORT_E_PINS_OUT <= 4'h0;
         PORT_E_PINS_OE  <= 4'h0;
         PORT_E_PU_EN    <= `PU_RESET4;
         PORT_E_PD_EN    <= `OSC_PD_RESET4;
         PORT_E_READ     <= 4'h0;
         OUTPUT_ONLY_PIN <= 1'b0;
         EXT_IRQ_PULSE   <= 4'h0;
         SERIAL_RX_IN    <= 1'b1;
         TIMER_COUNT_CLK <= 1'b0;
         CAPTURE_REG_A_TRIG <= 1'b0;
         CAPTURE_REG_B_TRIG <= 1'b0;
         TIMER_CAPTURE_IN <= 1'b0;
         SHARED_PIN_RESET_N <= 1'b0;
         SHARED_PIN_READ <= 1'b0;
         irq_prev_reg    <= 4'h0;
         ti_prev_reg     <= 1'b0;
         armed_reg       <= 1'b0;
         mode_reg        <= port_ctl_pkg::RESET_FUNC;
      end else begin
         PORT_A_PINS_OUT <= a_out;
         PORT_A_PINS_OE  <= a_oe;
         PORT_A_PU_EN    <= a_pu;
         PORT_A_READ     <= a_rd;
         PORT_B_PINS_OUT <= b_out;
         PORT_B_PINS_OE  <= b_oe;
         PORT_B_PU_EN    <= b_pu;
         PORT_B_READ     <= b_rd;
         ANALOG_INPUTS_EN <= b_an;
         PORT_C_PINS_OUT <= c_out;
         PORT_C_PINS_OE  <= c_oe;
         PORT_C_PU_EN    <= c_pu;
         PORT_C_READ     <= c_rd;
         PORT_D_PINS_OUT <= d_out;
         PORT_D_PINS_OE  <= d_oe;
         PORT_D_PU_EN    <= d_pu;
         PORT_D_READ     <= d_rd;
         PORT_E_PINS_OUT <= e_out;
         PORT_E_PINS_OE  <= e_oe;
         PORT_E_PU_EN    <= e_pu;
         PORT_E_PD_EN    <= e_pd;
         PORT_E_READ     <= e_rd;
         OUTPUT_ONLY_PIN <= OUTPUT_ONLY_DATA;
         EXT_IRQ_PULSE   <= irq_det;
         SERIAL_RX_IN    <= rx;
         TIMER_COUNT_CLK <= tclk;
         CAPTURE_REG_A_TRIG <= cap_a;
         CAPTURE_REG_B_TRIG <= cap_b;
         TIMER_CAPTURE_IN <= tcap;
         SHARED_PIN_RESET_N <= shared_rst_n;
         SHARED_PIN_READ <= shared_rd;
         irq_prev_reg    <= irq_prev_next;
         ti_prev_reg     <= ti_prev_next;
         armed_reg       <= armed_next;
         mode_reg        <= mode_next;
      end
   end
endmodule : port_pin_function_control
`default_nettype wire

/* File: tb/port_pin_function_control_properties.sv */
// Port-level checks for the port pin function block.
`timescale 1ns/1ps
`default_nettype none
module port_checks (
   input wire logic       CLK, RST_N, POWER_ON, RESET_SHARED_INPUT_PIN,
   input wire logic       SHARED_PIN_RESET_N, CAPTURE_REG_A_TRIG,
   input wire logic [3:0] PORT_A_DIRECTION, PORT_A_PULLUP, PORT_A_PINS_OE,
   input wire logic [3:0] PORT_A_PU_EN, PORT_B_ANALOG_SEL, PORT_B_PINS_OE,
   input wire logic [3:0] ANALOG_INPUTS_EN, PORT_C_PINS_IN, PORT_C_ALT_SEL,
   input wire logic [3:0] PORT_E_PU_EN, PORT_E_PD_EN, EXT_IRQ_PULSE,
   input wire logic [7:0] IRQ_EDGE_SEL
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_port_a_dir: assert property (
      $past(RST_N) |-> PORT_A_PINS_OE == ~$past(PORT_A_DIRECTION))
      else $error("port A enable does not follow direction");
   a_port_a_pull: assert property (
      $past(RST_N) |->
      PORT_A_PU_EN == ($past(PORT_A_PULLUP) & $past(PORT_A_DIRECTION)))
      else $error("port A pull-up wrong");
   a_analog_route: assert property (
      $past(RST_N) |-> ANALOG_INPUTS_EN == $past(PORT_B_ANALOG_SEL)
      && (PORT_B_PINS_OE & ANALOG_INPUTS_EN) == 4'h0)
      else $error("analog routing wrong");
   a_port_e_pull: assert property (
      (PORT_E_PU_EN & 4'h6) == 4'h0)
      else $error("port E middle pin pulled up");
   // Reset itself is the cause here, so this one must stay armed in reset.
   a_osc_pulldown: assert property (disable iff (1'b0)
      !RST_N |=> PORT_E_PD_EN == 4'h6)
      else $error("oscillator pins not pulled low in reset");
   a_irq_rise: assert property (
      $past(RST_N) && $rose(PORT_C_PINS_IN[0]) && IRQ_EDGE_SEL[0]
      |=> EXT_IRQ_PULSE[0])
      else $error("rising edge missed");
   a_capture_trig: assert property (
      $past(RST_N) && $rose(PORT_C_PINS_IN[0]) && PORT_C_ALT_SEL[0]
      |=> CAPTURE_REG_A_TRIG ##1 !CAPTURE_REG_A_TRIG)
      else $error("capture trigger not a single pulse");
   a_shared_reset: assert property (
      POWER_ON |-> ##2 SHARED_PIN_RESET_N == $past(RESET_SHARED_INPUT_PIN))
      else $error("shared pin not acting as reset");
endmodule : port_checks
bind port_pin_function_control port_checks chk (.*);
`default_nettype wire

/* File: tb/board_model.sv */
// Board around port A and the reset-shared pin.
`timescale 1ns/1ps
`default_nettype none
module board_model (
   input  wire logic [3:0] PORT_A_PINS_OUT, PORT_A_PINS_OE, PORT_A_PU_EN,
   input  wire logic [3:0] ext_level,
   input  wire logic       shared_low,
   output var  logic [3:0] PORT_A_PINS_IN,
   output var  logic       RESET_SHARED_INPUT_PIN
);
   // An undriven, unpulled pin follows the outside load, never a stale value.
   assign PORT_A_PINS_IN = (PORT_A_PINS_OE & PORT_A_PINS_OUT)
                         | (~PORT_A_PINS_OE & (PORT_A_PU_EN | ext_level));
   assign RESET_SHARED_INPUT_PIN = ~shared_low;
endmodule : board_model
`default_nettype wire

/* File: tb/test_port_pin_function_control.sv */
// Directed bench for the port pin function block.
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_function_control;
   logic CLK = 0, RST_N = 0, POWER_ON = 0, SHARED_PIN_AS_INPUT = 0;
   logic OUTPUT_ONLY_DATA = 0, TIMER_WIDE_OUT = 0, TIMER_NARROW_OUT = 0;
   logic SERIAL_TX_OUT = 0, shared_low = 0, RESET_SHARED_INPUT_PIN;
   logic [3:0] PORT_A_DIRECTION = '1, PORT_A_PULLUP = 0, PORT_A_OUT_DATA = 0;
   logic [3:0] PORT_B_DIRECTION = '1, PORT_B_PULLUP = 0, PORT_B_OUT_DATA = 0;
   logic [3:0] PORT_C_DIRECTION = '1, PORT_C_PULLUP = 0, PORT_C_OUT_DATA = 0;
   logic [3:0] PORT_E_DIRECTION = '1, PORT_E_PULLUP = 0, PORT_E_OUT_DATA = 0;
   logic [3:0] PORT_B_ANALOG_SEL = 0, PORT_B_PINS_IN = 0, PORT_C_ALT_SEL = 0;
   logic [3:0] PORT_C_PINS_IN = 0, PORT_E_PINS_IN = 0, ext_level = 0;
   logic [7:0] PORT_D_DIRECTION = '1, PORT_D_PULLUP = 0, PORT_D_ALT_SEL = 0;
   logic [7:0] PORT_D_OUT_DATA = 0, PORT_D_PINS_IN = 0, IRQ_EDGE_SEL = 0;
   logic [3:0] PORT_A_PINS_OUT, PORT_A_PINS_OE, PORT_A_PU_EN, PORT_A_READ;
   logic [3:0] PORT_B_PINS_OUT, PORT_B_PINS_OE, PORT_B_PU_EN, PORT_B_READ;
   logic [3:0] PORT_C_PINS_OUT, PORT_C_PINS_OE, PORT_C_PU_EN, PORT_C_READ;
   logic [3:0] PORT_E_PINS_OUT, PORT_E_PINS_OE, PORT_E_PU_EN, PORT_E_READ;
   logic [3:0] PORT_E_PD_EN, ANALOG_INPUTS_EN, EXT_IRQ_PULSE, PORT_A_PINS_IN;
   logic [7:0] PORT_D_PINS_OUT, PORT_D_PINS_OE, PORT_D_PU_EN, PORT_D_READ;
   logic SHARED_PIN_RESET_N, SHARED_PIN_READ, OUTPUT_ONLY_PIN, SERIAL_RX_IN;
   logic TIMER_COUNT_CLK, CAPTURE_REG_A_TRIG, CAPTURE_REG_B_TRIG;
   logic TIMER_CAPTURE_IN;
   int   err_total = 0;
   int   checked = 0;
   port_pin_function_control uut (.*);
   board_model board (.*);
   always #25 CLK = ~CLK;
   task automatic tick(input int n);
      repeat (n) @(negedge CLK);
   endtask : tick
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Records which interrupt lines and capture triggers pulsed over four cycles.
   task automatic irqs(input logic [5:0] exp);
      logic [5:0] seen;
      seen = 6'h00;
      repeat (4) begin
         tick(1);
         seen |= {CAPTURE_REG_B_TRIG, CAPTURE_REG_A_TRIG, EXT_IRQ_PULSE};
      end
      check(8'(seen), 8'(exp));
   endtask : irqs
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      tick(5);
      check({PORT_A_PINS_OE, PORT_A_PU_EN}, 8'h00);
      check(8'(PORT_E_PD_EN), 8'h06);
      RST_N = 1;
      OUTPUT_ONLY_DATA = 1;
      tick(2);
      check(8'(PORT_E_PD_EN), 8'h00);
      check(PORT_D_PINS_OE | PORT_D_PU_EN, 8'h00);
      check(8'(OUTPUT_ONLY_PIN), 8'h01);
      $display("reset test done");
      PORT_A_DIRECTION = 4'h5;
      PORT_A_OUT_DATA = 4'hA;
      PORT_A_PULLUP = 4'h3;
      PORT_B_DIRECTION = 4'h0;
      PORT_B_OUT_DATA = 4'hF;
      PORT_B_ANALOG_SEL = 4'h3;
      PORT_B_PINS_IN = 4'hF;
      PORT_D_DIRECTION = 8'h0F;
      PORT_D_PULLUP = 8'hFF;
      PORT_D_OUT_DATA = 8'hA5;
      PORT_E_PULLUP = 4'hF;
      tick(3);
      check({PORT_A_PINS_OE, PORT_A_PU_EN}, 8'hA1);
      check(8'(PORT_A_READ), 8'h0B);
      check({ANALOG_INPUTS_EN, PORT_B_PINS_OE}, 8'h3C);
      check(8'(PORT_B_READ), 8'h0C);
      check({PORT_B_PINS_OUT, PORT_B_PU_EN}, 8'hC0);
      check(PORT_D_PINS_OE, 8'hF0);
      check(PORT_D_PU_EN, 8'h0F);
      check(PORT_D_PINS_OUT, 8'hA0);
      check(8'(PORT_E_PU_EN), 8'h09);
      $display("port mode test done");
      PORT_C_DIRECTION = 4'hC;
      PORT_C_ALT_SEL = 4'h3;
      TIMER_WIDE_OUT = 1;
      IRQ_EDGE_SEL = 8'hB1;
      PORT_C_PULLUP = 4'hF;
      PORT_D_ALT_SEL = 8'h1C;
      TIMER_NARROW_OUT = 1;
      SERIAL_TX_OUT = 1;
      PORT_E_DIRECTION = 4'hE;
      PORT_E_OUT_DATA = 4'hF;
      PORT_E_PINS_IN = 4'h5;
      tick(2);
      check({PORT_C_PINS_OE, PORT_C_PINS_OUT}, 8'h22);
      check(8'(PORT_C_PU_EN), 8'h0D);
      check(PORT_D_PINS_OE, 8'hEC);
      check(PORT_D_PINS_OUT, 8'hAC);
      check(PORT_D_PU_EN, 8'h13);
      check({PORT_E_PINS_OE, PORT_E_PINS_OUT}, 8'h11);
      check(8'(PORT_E_PU_EN), 8'h08);
      check(8'(PORT_E_READ), 8'h05);
      PORT_C_PINS_IN = 4'h3;
      PORT_D_PINS_IN = 8'h02;
      irqs(6'h35);
      check({TIMER_COUNT_CLK, TIMER_CAPTURE_IN}, 8'h03);
      check(8'(SERIAL_RX_IN), 8'h00);
      check(PORT_D_READ, 8'h02);
      check(8'(PORT_C_READ), 8'h03);
      PORT_C_PINS_IN = 4'h0;
      PORT_D_PINS_IN = 8'h00;
      irqs(6'h0C);
      $display("alternate function test done");
      POWER_ON = 1;
      SHARED_PIN_AS_INPUT = 1;
      shared_low = 1;
      tick(3);
      check(8'(SHARED_PIN_RESET_N), 8'h00);
      POWER_ON = 0;
      shared_low = 0;
      tick(3);
      check({SHARED_PIN_RESET_N, SHARED_PIN_READ}, 8'h03);
      shared_low = 1;
      tick(3);
      check({SHARED_PIN_RESET_N, SHARED_PIN_READ}, 8'h02);
      shared_low = 0;
      $display("shared pin test done");
      end_of_test();
   end
endmodule : test_port_pin_function_control
`default_nettype wire
